/* File: rtl/fcd_cfg.svh */
// constants of the flash command decoder: codes, bit positions, offsets, resets
`ifndef FCD_CFG_SVH
`define FCD_CFG_SVH

// bus geometry
`define FCD_ADDR_W 22
`define FCD_DATA_W 16
`define FCD_NPART 4
`define FCD_PART_HI 21
`define FCD_PART_LO 20
`define FCD_CMD_HI 7
`define FCD_CFG_ADDR_HI 15

// command codes
`define FCD_CMD_READ_ARRAY 8'hFF
`define FCD_CMD_READ_STATUS 8'h70
`define FCD_CMD_READ_IDENT 8'h90
`define FCD_CMD_READ_QUERY 8'h98
`define FCD_CMD_CLEAR_STATUS 8'h50
`define FCD_CMD_PROG_SETUP 8'h40
`define FCD_CMD_PROG_ALT 8'h10
`define FCD_CMD_FAST_SETUP 8'h30
`define FCD_CMD_ERASE_SETUP 8'h20
`define FCD_CMD_CONFIRM 8'hD0
`define FCD_CMD_SUSPEND 8'hB0
`define FCD_CMD_LOCK_SETUP 8'h60
`define FCD_CMD_LOCK_BLOCK 8'h01
`define FCD_CMD_LOCK_DOWN 8'h2F
`define FCD_CMD_SET_CONFIG 8'h03
`define FCD_CMD_PROT_SETUP 8'hC0

// flash_status_reg bit positions
`define FCD_SR_READY 7
`define FCD_SR_ESUS 6
`define FCD_SR_ERASE 5
`define FCD_SR_PROG 4
`define FCD_SR_VPP 3
`define FCD_SR_PSUS 2
`define FCD_SR_LOCK 1
`define FCD_SR_W 8

// reset values
`define FCD_SR_RST 8'h80
`define FCD_CFG_ASYNC_BIT 15
`define FCD_CFG_RST 16'h8000
`define FCD_CTRL_EN_RST 1'b1

// wishbone register offsets (byte addresses)
`define FCD_WB_ADR_W 4
`define FCD_OFS_STATUS 4'h0
`define FCD_OFS_CONFIG 4'h4
`define FCD_OFS_MODES 4'h8
`define FCD_OFS_CTRL 4'hC
`define FCD_CTRL_EN_BIT 0

`endif

/* File: rtl/fcd_pkg.sv */
// types of the flash command decoder
`include "fcd_cfg.svh"

package fcd_pkg;

    // per-partition read mode
    typedef enum logic [1:0] {RD_ARRAY, RD_STATUS, RD_IDENT, RD_QUERY} fcd_rmode_type;

    // command sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_PGM_SETUP, ST_FAST_SETUP, ST_FAST_RUN,
        ST_ERASE_SETUP, ST_LOCK_SETUP, ST_PROT_SETUP
    } fcd_state_type;

    // operation handed to the embedded_algorithm_engine
    typedef enum logic [1:0] {OP_PROGRAM, OP_FAST, OP_ERASE, OP_PROT} fcd_op_type;

    // block lock actions
    typedef enum logic [1:0] {LK_LOCK, LK_UNLOCK, LK_DOWN} fcd_lock_type;

    // all state of the decoder top
    typedef struct packed {
        fcd_state_type st;
        fcd_op_type op;
        logic [1:0] busy_part;
        fcd_rmode_type [`FCD_NPART-1:0] modes;
        logic [`FCD_SR_W-1:0] sr;
        logic [`FCD_DATA_W-1:0] cfg;
        logic ctrl_en;
        logic ce_d;
        logic oe_d;
        logic we_d;
        logic [`FCD_SR_W-1:0] snap;
        logic [`FCD_DATA_W-1:0] dq_out;
        logic dq_oe;
        logic byte_only;
        fcd_rmode_type rd_mode;
        logic eng_start;
        fcd_op_type eng_op;
        logic [`FCD_ADDR_W-1:0] eng_addr;
        logic [`FCD_DATA_W-1:0] eng_data;
        logic eng_susp;
        logic eng_res;
        logic lock_req;
        fcd_lock_type lock_act;
        logic [`FCD_ADDR_W-1:0] lock_addr;
        logic wb_ack;
        logic [31:0] wb_dat;
    } fcd_regs_type;

endpackage

/* File: rtl/fcd_sync.sv */
// two flip-flop synchroniser for a vector of levels
`timescale 1ns/1ns

module fcd_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stage;
    } fcd_sync_state_type;

    fcd_sync_state_type r;
    fcd_sync_state_type n;

    // meta feeds only the second stage
    always_comb
    begin
        n = r;
        n.meta = i_async;
        n.stage = r.meta;
    end

    // register the chain
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            r <= {RST_VAL, RST_VAL};
        end
        else
        begin
            r <= n;
        end
    end

    assign o_sync = r.stage;

endmodule

/* File: rtl/fcd_top.sv */
// command_decoder of a multi-partition nor flash with wishbone register access
`timescale 1ns/1ns
`include "fcd_cfg.svh"

// Summary of operation
// (RULE1) FFh puts partition in array read
// (RULE2) 70h or program/erase gives status mode
// (RULE3) 90h identifier mode, full sixteen data lines
// (RULE4) 98h query mode, low byte only
// (RULE5) engine sets error flags, never clears
// (RULE6) sticky flags cleared by reset or 50h
// (RULE7) word program: 40h then address and data
// (RULE8) 10h acts like 40h
// (RULE9) status snapshot refreshed on ce/oe toggle
// (RULE10) host issues FFh to read array again
// (RULE11) 30h+D0h fast program, other commands ignored
// (RULE12) erase: 20h then D0h at block
// (RULE13) bad erase confirm: seq error, status mode
// (RULE14) busy partition takes only 70h and B0h
// (RULE15) B0h suspends; ready plus suspend bit
// (RULE16) suspension held until reset or resume
// (RULE17) D0h while suspended resumes the operation
// (RULE18) 60h then 01h/D0h/2Fh: lock/unlock/lockdown
// (RULE19) unlock of locked-down block does nothing
// (RULE20) bad lock second code: sequence error
// (RULE21) C0h then protection program, status mode
// (RULE22) 60h+03h loads config from low address
// (RULE23) reset: array mode, status 80h, async config
// (RULE24) write captured on write strobe rising edge
// (RULE25) host runs one program/erase at once
// (RULE26) write between setup and confirm: error
// (RULE27) read mode kept per partition, upper bits
module fcd_top (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic i_addr_valid_n,
    input wire logic [`FCD_ADDR_W-1:0] i_addr,
    input wire logic [`FCD_DATA_W-1:0] i_dq_in,
    output logic [`FCD_DATA_W-1:0] o_dq_out,
    output logic o_dq_oe,
    output logic o_dq_byte_only,
    output logic [1:0] o_rd_mode,
    output logic o_eng_start,
    output logic [1:0] o_eng_op,
    output logic [`FCD_ADDR_W-1:0] o_eng_addr,
    output logic [`FCD_DATA_W-1:0] o_eng_data,
    output logic o_eng_suspend,
    output logic o_eng_resume,
    input wire logic i_eng_busy,
    input wire logic i_eng_suspended,
    input wire logic i_eng_err_lock,
    input wire logic i_eng_err_vpp,
    input wire logic i_eng_err_prog,
    input wire logic i_eng_err_erase,
    output logic o_lock_req,
    output logic [1:0] o_lock_act,
    output logic [`FCD_ADDR_W-1:0] o_lock_addr,
    input wire logic i_blk_locked_down,
    output logic [`FCD_DATA_W-1:0] o_cfg_reg,
    output logic [`FCD_SR_W-1:0] o_status,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [`FCD_WB_ADR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack
);

    localparam fcd_pkg::fcd_regs_type REGS_RST = '{
        st: fcd_pkg::ST_IDLE, op: fcd_pkg::OP_PROGRAM, busy_part: 2'h0,
        modes: {`FCD_NPART{fcd_pkg::RD_ARRAY}}, sr: `FCD_SR_RST, cfg: `FCD_CFG_RST,
        ctrl_en: `FCD_CTRL_EN_RST, ce_d: 1'b1, oe_d: 1'b1, we_d: 1'b1, snap: `FCD_SR_RST,
        dq_out: '0, dq_oe: 1'b0, byte_only: 1'b0, rd_mode: fcd_pkg::RD_ARRAY,
        eng_start: 1'b0, eng_op: fcd_pkg::OP_PROGRAM, eng_addr: '0, eng_data: '0,
        eng_susp: 1'b0, eng_res: 1'b0, lock_req: 1'b0, lock_act: fcd_pkg::LK_LOCK,
        lock_addr: '0, wb_ack: 1'b0, wb_dat: '0
    };

    logic rst_sync_n;
    logic [3:0] ctl_s;
    logic [`FCD_ADDR_W+`FCD_DATA_W-1:0] bus_s;
    fcd_pkg::fcd_regs_type r, n;

    // reset release through two flops
    fcd_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_rst_sync (.i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n), .i_async(1'b1), .o_sync(rst_sync_n));

    // control pins: adv, we, oe, ce (idle high)
    fcd_sync #(.WIDTH(4), .RST_VAL(4'hF)) u_ctl_sync (.i_core_clk(i_core_clk),
        .i_rst_n(rst_sync_n), .i_async({i_addr_valid_n, i_we_n, i_oe_n, i_ce_n}),
        .o_sync(ctl_s));

    // address and data pins
    fcd_sync #(.WIDTH(`FCD_ADDR_W+`FCD_DATA_W), .RST_VAL('0)) u_bus_sync (
        .i_core_clk(i_core_clk), .i_rst_n(rst_sync_n), .i_async({i_addr, i_dq_in}),
        .o_sync(bus_s));

    // command decode, status upkeep, read path and bus slave
    always_comb
    begin
        logic ce_n, oe_n, we_n, adv_n;
        logic [`FCD_ADDR_W-1:0] addr;
        logic [`FCD_DATA_W-1:0] dq;
        logic [7:0] cmd;
        logic [1:0] wpart;
        logic wr_ev, busy_run, seq_err, clr_sticky;
        logic [`FCD_SR_W-1:0] set_mask, clr_mask;
        {adv_n, we_n, oe_n, ce_n} = ctl_s;
        {addr, dq} = bus_s;
        cmd = dq[`FCD_CMD_HI:0];
        wpart = addr[`FCD_PART_HI:`FCD_PART_LO]; // [RULE27]
        seq_err = 1'b0;
        clr_sticky = 1'b0;
        set_mask = 8'h00;
        clr_mask = 8'h00;
        busy_run = i_eng_busy & ~i_eng_suspended;
        n = r;
        n.eng_start = 1'b0;
        n.eng_susp = 1'b0;
        n.eng_res = 1'b0;
        n.lock_req = 1'b0;
        n.we_d = we_n;
        n.ce_d = ce_n;
        n.oe_d = oe_n;
        // write taken at the write strobe rise
        wr_ev = ~r.we_d & we_n & ~ce_n & ~adv_n & r.ctrl_en; // [RULE24]

        if (wr_ev)
        begin
            unique case (r.st)
                fcd_pkg::ST_IDLE:
                begin
                    if (busy_run && wpart == r.busy_part)
                    begin
                        // running partition: only status read and suspend
                        if (cmd == `FCD_CMD_READ_STATUS)
                            n.modes[wpart] = fcd_pkg::RD_STATUS; // [RULE14]
                        else if (cmd == `FCD_CMD_SUSPEND)
                            n.eng_susp = 1'b1; // [RULE14] [RULE15]
                    end
                    else
                    begin
                        unique case (cmd)
                            `FCD_CMD_READ_ARRAY: n.modes[wpart] = fcd_pkg::RD_ARRAY; // [RULE1]
                            `FCD_CMD_READ_STATUS: n.modes[wpart] = fcd_pkg::RD_STATUS; // [RULE2]
                            `FCD_CMD_READ_IDENT: n.modes[wpart] = fcd_pkg::RD_IDENT; // [RULE3]
                            `FCD_CMD_READ_QUERY: n.modes[wpart] = fcd_pkg::RD_QUERY; // [RULE4]
                            `FCD_CMD_CLEAR_STATUS: clr_sticky = 1'b1; // [RULE6]
                            `FCD_CMD_PROG_SETUP, `FCD_CMD_PROG_ALT:
                            begin
                                n.st = fcd_pkg::ST_PGM_SETUP; // [RULE7] [RULE8]
                                n.modes[wpart] = fcd_pkg::RD_STATUS;
                            end
                            `FCD_CMD_FAST_SETUP:
                            begin
                                n.st = fcd_pkg::ST_FAST_SETUP; // [RULE11]
                                n.modes[wpart] = fcd_pkg::RD_STATUS;
                            end
                            `FCD_CMD_ERASE_SETUP:
                            begin
                                n.st = fcd_pkg::ST_ERASE_SETUP; // [RULE12]
                                n.modes[wpart] = fcd_pkg::RD_STATUS;
                            end
                            `FCD_CMD_LOCK_SETUP:
                                n.st = fcd_pkg::ST_LOCK_SETUP; // [RULE18] [RULE22]
                            `FCD_CMD_PROT_SETUP:
                            begin
                                n.st = fcd_pkg::ST_PROT_SETUP; // [RULE21]
                                n.modes[wpart] = fcd_pkg::RD_STATUS;
                            end
                            `FCD_CMD_SUSPEND:
                                n.eng_susp = busy_run; // [RULE15]
                            `FCD_CMD_CONFIRM:
                                n.eng_res = i_eng_suspended; // [RULE17]
                            default:
                                n.st = r.st; // unassigned codes ignored
                        endcase
                    end
                end
                fcd_pkg::ST_PGM_SETUP, fcd_pkg::ST_PROT_SETUP:
                begin
                    // second cycle carries target address and data
                    n.eng_start = 1'b1; // [RULE7] [RULE21]
                    n.eng_op = (r.st == fcd_pkg::ST_PGM_SETUP) ?
                        fcd_pkg::OP_PROGRAM : fcd_pkg::OP_PROT;
                    n.op = n.eng_op;
                    n.eng_addr = addr;
                    n.eng_data = dq;
                    n.busy_part = wpart;
                    n.modes[wpart] = fcd_pkg::RD_STATUS; // [RULE2]
                    n.st = fcd_pkg::ST_IDLE;
                end
                fcd_pkg::ST_FAST_SETUP:
                begin
                    if (cmd == `FCD_CMD_CONFIRM)
                    begin
                        n.st = fcd_pkg::ST_FAST_RUN; // [RULE11]
                        n.busy_part = wpart;
                        n.op = fcd_pkg::OP_FAST;
                        n.eng_addr = addr;
                    end
                    else
                    begin
                        seq_err = 1'b1; // [RULE26]
                        n.st = fcd_pkg::ST_IDLE;
                    end
                end
                fcd_pkg::ST_FAST_RUN:
                begin
                    if (wpart == r.busy_part)
                    begin
                        // every write is program data, never a command
                        n.eng_start = 1'b1; // [RULE11]
                        n.eng_op = fcd_pkg::OP_FAST;
                        n.eng_addr = addr;
                        n.eng_data = dq;
                    end
                    else
                        n.st = fcd_pkg::ST_IDLE; // another partition ends it
                end
                fcd_pkg::ST_ERASE_SETUP:
                begin
                    if (cmd == `FCD_CMD_CONFIRM)
                    begin
                        n.eng_start = 1'b1; // [RULE12]
                        n.eng_op = fcd_pkg::OP_ERASE;
                        n.op = fcd_pkg::OP_ERASE;
                        n.eng_addr = addr;
                        n.eng_data = dq;
                        n.busy_part = wpart;
                    end
                    else
                        seq_err = 1'b1; // [RULE13] [RULE26]
                    n.modes[wpart] = fcd_pkg::RD_STATUS; // [RULE13]
                    n.st = fcd_pkg::ST_IDLE;
                end
                fcd_pkg::ST_LOCK_SETUP:
                begin
                    n.lock_addr = addr;
                    unique case (cmd)
                        `FCD_CMD_LOCK_BLOCK:
                        begin
                            n.lock_req = 1'b1; // [RULE18]
                            n.lock_act = fcd_pkg::LK_LOCK;
                        end
                        `FCD_CMD_CONFIRM:
                        begin
                            n.lock_req = ~i_blk_locked_down; // [RULE18] [RULE19]
                            n.lock_act = fcd_pkg::LK_UNLOCK;
                        end
                        `FCD_CMD_LOCK_DOWN:
                        begin
                            n.lock_req = 1'b1; // [RULE18]
                            n.lock_act = fcd_pkg::LK_DOWN;
                        end
                        `FCD_CMD_SET_CONFIG:
                        begin
                            n.cfg = addr[`FCD_CFG_ADDR_HI:0]; // [RULE22]
                            n.modes[wpart] = fcd_pkg::RD_ARRAY; // [RULE22]
                        end
                        default:
                            seq_err = 1'b1; // [RULE20] [RULE22] [RULE26]
                    endcase
                    n.st = fcd_pkg::ST_IDLE;
                end
            endcase
        end

        // status: live ready/suspend bits, sticky error bits
        n.sr[`FCD_SR_READY] = ~i_eng_busy | i_eng_suspended; // [RULE15]
        n.sr[`FCD_SR_ESUS] = i_eng_suspended & (r.op == fcd_pkg::OP_ERASE); // [RULE15] [RULE16]
        n.sr[`FCD_SR_PSUS] = i_eng_suspended & (r.op != fcd_pkg::OP_ERASE); // [RULE15] [RULE16]
        set_mask[`FCD_SR_LOCK] = i_eng_err_lock; // [RULE5]
        set_mask[`FCD_SR_VPP] = i_eng_err_vpp; // [RULE5]
        set_mask[`FCD_SR_PROG] = i_eng_err_prog | seq_err; // [RULE5] [RULE13]
        set_mask[`FCD_SR_ERASE] = i_eng_err_erase | seq_err; // [RULE5] [RULE13]
        clr_mask[`FCD_SR_LOCK] = clr_sticky;
        clr_mask[`FCD_SR_VPP] = clr_sticky;
        clr_mask[`FCD_SR_PROG] = clr_sticky;
        clr_mask[`FCD_SR_ERASE] = clr_sticky;
        // a set in the clearing cycle wins
        n.sr = (n.sr & ~clr_mask) | set_mask; // [RULE5] [RULE6]

        // read path for the addressed partition
        n.rd_mode = r.modes[wpart]; // [RULE27]
        n.dq_oe = ~ce_n & ~oe_n & we_n;
        if ((r.ce_d & ~ce_n) | (r.oe_d & ~oe_n))
        begin
            n.snap = r.sr; // [RULE9]
        end
        n.dq_out = (r.rd_mode == fcd_pkg::RD_STATUS) ? {8'h00, r.snap} : 16'h0000;
        n.byte_only = (r.rd_mode == fcd_pkg::RD_QUERY); // [RULE3] [RULE4]

        // wishbone classic slave, one wait state
        n.wb_ack = i_wb_cyc & i_wb_stb & ~r.wb_ack;
        if (n.wb_ack)
        begin
            unique case (i_wb_adr)
                `FCD_OFS_STATUS: n.wb_dat = {24'h000000, r.sr};
                `FCD_OFS_CONFIG: n.wb_dat = {16'h0000, r.cfg};
                `FCD_OFS_MODES: n.wb_dat = {24'h000000, r.modes};
                `FCD_OFS_CTRL: n.wb_dat = {31'h00000000, r.ctrl_en};
                default: n.wb_dat = 32'h00000000;
            endcase
            if (i_wb_we && i_wb_adr == `FCD_OFS_CTRL && i_wb_sel[0])
                n.ctrl_en = i_wb_dat[`FCD_CTRL_EN_BIT];
        end
    end

    // single register of the whole state
    always_ff @(posedge i_core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            r <= REGS_RST; // [RULE23]
        else
            r <= n;
    end

    // outputs straight from the state register
    assign o_dq_out = r.dq_out;
    assign o_dq_oe = r.dq_oe;
    assign o_dq_byte_only = r.byte_only;
    assign o_rd_mode = r.rd_mode;
    assign o_eng_start = r.eng_start;
    assign o_eng_op = r.eng_op;
    assign o_eng_addr = r.eng_addr;
    assign o_eng_data = r.eng_data;
    assign o_eng_suspend = r.eng_susp;
    assign o_eng_resume = r.eng_res;
    assign o_lock_req = r.lock_req;
    assign o_lock_act = r.lock_act;
    assign o_lock_addr = r.lock_addr;
    assign o_cfg_reg = r.cfg;
    assign o_status = r.sr;
    assign o_wb_dat = r.wb_dat;
    assign o_wb_ack = r.wb_ack;

endmodule

/* File: test/fcd_eng_model.sv */
// behavioural embedded_algorithm_engine: runs, suspends, fails on command
`timescale 1ns/1ns
module fcd_eng_model #(parameter int RUN = 40) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [1:0] i_op,
    input wire logic i_suspend,
    input wire logic i_resume,
    input wire logic i_fail,
    output logic o_busy,
    output logic o_suspended,
    output logic o_err_prog,
    output logic o_err_erase
);
    int cnt;
    logic er;
    // countdown frozen while suspended
    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt <= 0;
            o_suspended <= 1'b0;
        end
        else if (i_start)
        begin
            cnt <= RUN;
            er <= i_op == 2'h2;
        end
        else if (i_suspend && cnt > 0)
            o_suspended <= 1'b1;
        else if (i_resume)
            o_suspended <= 1'b0;
        else if (cnt > 0 && !o_suspended)
            cnt <= cnt - 1;
    end
    // error pulse on the last running cycle, never a clear
    assign o_busy = cnt > 0 && !o_suspended;
    assign o_err_prog = i_fail && !er && cnt == 1 && !o_suspended;
    assign o_err_erase = i_fail && er && cnt == 1 && !o_suspended;
endmodule

/* File: test/fcd_properties.sv */
// port checks of the flash command decoder
`timescale 1ns/1ns
`include "fcd_cfg.svh"
module fcd_properties (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [`FCD_DATA_W-1:0] i_dq_in,
    input wire logic [`FCD_SR_W-1:0] o_status,
    input wire logic [`FCD_DATA_W-1:0] o_cfg_reg,
    input wire logic [1:0] o_rd_mode,
    input wire logic o_dq_byte_only,
    input wire logic [`FCD_DATA_W-1:0] o_dq_out,
    input wire logic o_eng_start,
    input wire logic i_eng_err_prog,
    input wire logic i_eng_suspended
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // suspension shows as ready plus a suspend flag
    sequence s_susp;
        o_status[`FCD_SR_READY] && (o_status[`FCD_SR_PSUS] || o_status[`FCD_SR_ESUS]);
    endsequence
    property p_rst; $rose(i_rst_n) |-> o_status == `FCD_SR_RST && o_cfg_reg == `FCD_CFG_RST; endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
    property p_err; i_eng_err_prog |-> ##[1:2] o_status[`FCD_SR_PROG]; endproperty
    a_err: assert property (p_err) else $error("error flag not set");
    property p_clr;
        $fell(o_status[`FCD_SR_PROG]) |-> $past(i_dq_in[7:0], 3) == `FCD_CMD_CLEAR_STATUS;
    endproperty
    a_clr: assert property (p_clr) else $error("flag cleared without clear");
    property p_start; o_eng_start |=> !o_eng_start; endproperty
    a_start: assert property (p_start) else $error("start not a pulse");
    property p_susp; $rose(i_eng_suspended) |-> ##[1:2] s_susp; endproperty
    a_susp: assert property (p_susp) else $error("suspend not shown");
    property p_query; o_dq_byte_only == ($past(o_rd_mode) == 2'h3); endproperty
    a_query: assert property (p_query) else $error("byte lane flag wrong");
    property p_dq; o_rd_mode != 2'h1 |=> o_dq_out == 16'h0000; endproperty
    a_dq: assert property (p_dq) else $error("status outside status mode");
    property p_cfg; $changed(o_cfg_reg) |-> $past(i_dq_in[7:0], 3) == `FCD_CMD_SET_CONFIG; endproperty
    a_cfg: assert property (p_cfg) else $error("config changed unasked");
endmodule

/* File: test/testbench.sv */
// self-checking bench of the flash command decoder
`timescale 1ns/1ns
`include "fcd_cfg.svh"
module testbench;
    logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_ce_n = 1'b1, i_oe_n = 1'b1, i_we_n = 1'b1;
    logic i_addr_valid_n = 1'b0, i_blk_locked_down = 1'b0, i_wb_cyc = 1'b0, i_wb_stb = 1'b0;
    logic i_wb_we = 1'b0, fail = 1'b0, o_dq_oe, o_dq_byte_only, o_eng_start, o_eng_suspend;
    logic o_eng_resume, o_lock_req, o_wb_ack, i_eng_busy, i_eng_suspended;
    logic i_eng_err_lock = 1'b0, i_eng_err_vpp = 1'b0, i_eng_err_prog, i_eng_err_erase;
    logic [3:0] i_wb_adr = 4'h0, i_wb_sel = 4'hF;
    logic [31:0] i_wb_dat = 32'h0, o_wb_dat, rd;
    logic [21:0] i_addr = 22'h0, o_eng_addr, o_lock_addr;
    logic [15:0] i_dq_in = 16'h0, o_dq_out, o_eng_data, o_cfg_reg;
    logic [7:0] o_status, mc [4] = '{8'hFF, 8'h70, 8'h90, 8'h98}, lc [3] = '{8'h01, 8'hD0, 8'h2F};
    logic [1:0] o_rd_mode, o_eng_op, o_lock_act, last_op, last_act;
    int n_errors = 0, n_tests = 0, n_st = 0, n_lk = 0;
    fcd_top dut_u (.*);
    fcd_eng_model eng_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_start(o_eng_start),
        .i_op(o_eng_op), .i_suspend(o_eng_suspend), .i_resume(o_eng_resume), .i_fail(fail),
        .o_busy(i_eng_busy), .o_suspended(i_eng_suspended), .o_err_prog(i_eng_err_prog),
        .o_err_erase(i_eng_err_erase));
    initial forever #4 i_core_clk = ~i_core_clk;
    // records launches and lock requests
    always @(posedge i_core_clk)
    begin
        if (o_eng_start === 1'b1)
            {n_st, last_op} <= {n_st + 1, o_eng_op};
        if (o_lock_req === 1'b1)
            {n_lk, last_act} <= {n_lk + 1, o_lock_act};
    end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            n_errors++;
            $display("ERROR %0t seen %h want %h", $time, s, e);
        end
    endtask
    // one classic wishbone cycle, held until ack
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'h3, w, a, d};
        do @(posedge i_core_clk); while (o_wb_ack !== 1'b1);
        rd = o_wb_dat;
        {i_wb_cyc, i_wb_stb} <= 2'h0;
        @(posedge i_core_clk);
    endtask
    task automatic wbc(input logic [3:0] a, input logic [31:0] e);
        wb(1'h0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic idle();
        while (i_eng_busy !== 1'b0) @(posedge i_core_clk);
    endtask
    // pin write: settle, then strobe pulse
    task automatic pw(input logic [1:0] p, input logic [7:0] c, input logic [15:0] lo);
        @(posedge i_core_clk);
        {i_ce_n, i_addr, i_dq_in} <= {1'h0, p, 4'h0, lo, 8'h00, c};
        repeat (3) @(posedge i_core_clk);
        i_we_n <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        i_we_n <= 1'b1;
        repeat (8) @(posedge i_core_clk);
    endtask
    // pin read with an output enable toggle
    task automatic pr(input logic [1:0] p, input logic [15:0] e);
        @(posedge i_core_clk);
        {i_addr, i_oe_n} <= {p, 20'h0, 1'h0};
        repeat (6) @(posedge i_core_clk);
        chk(32'(o_dq_out), 32'(e));
        i_oe_n <= 1'b1;
    endtask
    initial
    begin
        repeat (6) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        wbc(`FCD_OFS_STATUS, 32'h80);
        wbc(`FCD_OFS_CONFIG, 32'h8000);
        wbc(4'h2, 32'h0);
        wb(1'h1, `FCD_OFS_CTRL, 32'h0);
        pw(2'h1, 8'h70, 16'h0);
        wbc(`FCD_OFS_MODES, 32'h0);
        wb(1'h1, `FCD_OFS_CTRL, 32'h1);
        foreach (mc[i])
        begin
            pw(2'h1, mc[i], 16'h0);
            wbc(`FCD_OFS_MODES, 32'(i) << 2);
        end
        pw(2'h2, 8'h40, 16'h0);
        pw(2'h2, 8'h5A, 16'h0123);
        chk(32'({o_eng_data, 2'(n_st), last_op}), 32'h5A4);
        chk(32'(o_eng_addr), 32'h200123);
        pw(2'h2, 8'h90, 16'h0);
        wbc(`FCD_OFS_MODES, 32'h1C);
        idle();
        wbc(`FCD_OFS_MODES, 32'h1C);
        pr(2'h2, 16'h0080);
        fail <= 1'b1;
        pw(2'h2, 8'h10, 16'h0);
        pw(2'h2, 8'hA5, 16'h0456);
        chk(32'({o_eng_addr, 2'(n_st), last_op}), 32'({22'h200456, 4'h8}));
        idle();
        fail <= 1'b0;
        pw(2'h2, 8'hFF, 16'h0);
        wbc(`FCD_OFS_STATUS, 32'h90);
        pw(2'h0, 8'h50, 16'h0);
        wbc(`FCD_OFS_STATUS, 32'h80);
        pw(2'h3, 8'h20, 16'h4000);
        pw(2'h3, 8'hD0, 16'h8000);
        chk(32'({o_eng_addr, 2'(n_st), last_op}), 32'({22'h308000, 4'hE}));
        pw(2'h0, 8'hB0, 16'h0);
        pr(2'h3, 16'h00C0);
        pw(2'h1, 8'hD0, 16'h0);
        wbc(`FCD_OFS_STATUS, 32'h0);
        idle();
        pw(2'h2, 8'h20, 16'h0);
        pw(2'h2, 8'hFF, 16'h0);
        wbc(`FCD_OFS_STATUS, 32'hB0);
        wbc(`FCD_OFS_MODES, 32'h5C);
        pw(2'h0, 8'h50, 16'h0);
        foreach (lc[i])
        begin
            pw(2'h1, 8'h60, 16'h0);
            pw(2'h1, lc[i], 16'h0);
            chk(32'({2'(n_lk), last_act}), 32'({2'(i + 1), 2'(i)}));
        end
        i_blk_locked_down <= 1'b1;
        pw(2'h1, 8'h60, 16'h0);
        pw(2'h1, 8'hD0, 16'h0);
        chk(32'(n_lk), 32'h3);
        pw(2'h1, 8'h60, 16'h0);
        pw(2'h1, 8'h55, 16'h0);
        wbc(`FCD_OFS_STATUS, 32'hB0);
        pw(2'h0, 8'h60, 16'h0);
        pw(2'h0, 8'h03, 16'h1234);
        chk(32'(o_cfg_reg), 32'h1234);
        pw(2'h0, 8'h30, 16'h0);
        pw(2'h0, 8'hD0, 16'h0);
        pw(2'h0, 8'h70, 16'h0);
        chk(32'({o_eng_data, last_op}), 32'h1C1);
        pw(2'h1, 8'hFF, 16'h0);
        idle();
        pw(2'h0, 8'hC0, 16'h0);
        pw(2'h0, 8'h77, 16'h0080);
        chk(32'({3'(n_st), last_op}), 32'h17);
        wb(1'h0, `FCD_OFS_MODES, 32'h0);
        chk(32'(rd[1:0]), 32'h1);
        idle();
        report_and_stop();
    end
    // stops a hung run
    initial
    begin
        repeat (20000) @(posedge i_core_clk);
        n_errors++;
        report_and_stop();
    end
endmodule
bind fcd_top fcd_properties chk_u (.*);
